/* File: src/srp_defs.svh */
// constants of the serial register port: offsets, fields, reset values, counts
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SRP_ADDR_W            6
`define SRP_DATA_W            8
`define SRP_OFS_GCFG          6'h0f
`define SRP_OFS_CCH           6'h14
`define SRP_OFS_TCTL          6'h15

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SRP_GCFG_SPLIT_BIT    0
`define SRP_GCFG_SRST_BIT     7
`define SRP_GCFG_RST          8'h00
`define SRP_TCTL_SLOT_EN_BIT  0
`define SRP_TCTL_RST          8'h00
`define SRP_CCH_RST           8'h00

// ----------------------------------------------------------------
// transfer and frame counts
// ----------------------------------------------------------------
`define SRP_CMD_BITS          5'h08
`define SRP_XFER_BITS         5'h10
`define SRP_CH1_SLOT          5'h01
`define SRP_CH1_LAST_BIT      8'h0f

`endif

/* File: src/srp_pkg.sv */
// types shared by the serial register port modules
package srp_pkg;

	// command byte as shifted in, lsb first
	typedef struct packed {
		logic       rd;
		logic       spare;
		logic [5:0] addr;
	} srp_cmd_t;

	// request word handed from the link domain to the system domain
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] data;
	} srp_req_t;

endpackage : srp_pkg

/* File: src/srp_sync.sv */
// three-stage input synchroniser, a change counts once stages two and three agree
module srp_sync #(
	parameter int W = 1
) (
	// clock and control
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	// data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] agree;

	assign agree = ~(s2_r ^ s3_r);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_o  <= '0;
		end
		else if (ce_i)
		begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_o  <= (s3_r & agree) | (q_o & ~agree);
		end
	end

endmodule : srp_sync

/* File: src/srp_regmem.sv */
// readback store for the register map, registered read data
`include "srp_defs.svh"

module srp_regmem (
	// clock and control
	input  wire logic                    clk_i,
	input  wire logic                    ce_i,
	// write port
	input  wire logic                    we_i,
	input  wire logic [`SRP_ADDR_W-1:0]  waddr_i,
	input  wire logic [`SRP_DATA_W-1:0]  wdata_i,
	// read port
	input  wire logic [`SRP_ADDR_W-1:0]  raddr_i,
	output logic      [`SRP_DATA_W-1:0]  rdata_o
);
	logic [`SRP_DATA_W-1:0] mem [0:(1<<`SRP_ADDR_W)-1];

	// no reset on purpose: contents are only verify copies of host writes
	always_ff @(posedge clk_i)
	begin
		if (ce_i)
		begin
			if (we_i)
				mem[waddr_i] <= wdata_i;
			rdata_o <= mem[raddr_i];
		end
	end

endmodule : srp_regmem

/* File: src/srp_port.sv */
// serial register port with general config and double-buffered control channel
`include "srp_defs.svh"

module srp_port (
	// system clock domain
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// serial port, link clock domain
	input  wire logic sclk_i,
	input  wire logic cs_n_i,
	input  wire logic data_pin_a_i,
	output logic      data_pin_a_o,
	output logic      data_pin_a_oe_o,
	output logic      data_pin_b_o,
	output logic      data_pin_b_oe_o,
	// tdm link pins
	input  wire logic tdm_c4_i,
	input  wire logic tdm_frame_n_i,
	input  wire logic tdm_in_i,
	output logic      tdm_out_o,
	output logic      tdm_out_oe_o
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic                  link_rst_r;
	logic [4:0]            bit_cnt_r;
	srp_pkg::srp_cmd_t     cmd_r;
	srp_pkg::srp_cmd_t     cmd_nxt;
	logic [7:0]            rx_sh_r;
	logic [6:0]            tx_sh_r;
	logic                  out_bit_r;
	logic                  drive_r;
	logic                  rd_tgl_r;
	logic                  wr_tgl_r;
	srp_pkg::srp_req_t     req_r;
	logic [4:0]            sync_q;
	logic                  rd_s;
	logic                  wr_s;
	logic                  c4_s;
	logic                  frame_n_s;
	logic                  tin_s;
	logic                  rd_seen_r;
	logic                  wr_seen_r;
	logic                  rd_evt;
	logic                  wr_evt;
	logic                  rd_pend_r;
	logic [7:0]            mem_q;
	logic [7:0]            rd_data_r;
	logic [7:0]            gcfg_r;
	logic [7:0]            tctl_r;
	logic [7:0]            cch_tx_buf_r;
	logic [7:0]            cch_tx_cur_r;
	logic [7:0]            cch_rx_sh_r;
	logic [7:0]            cch_rx_hold_r;
	logic                  split;
	logic                  slot_en;
	logic                  c4_d_r;
	logic                  tdm_fall;
	logic                  tdm_frame;
	logic [7:0]            idx_r;
	logic                  half_r;
	logic [7:0]            idx_nxt;
	logic                  cell_start;
	logic                  nxt_in_ch1;
	logic                  in_ch1;

	// ----------------------------------------------------------------
	// link domain: bit counter and shifters
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		link_rst_r <= rst_i;
	end

	assign cmd_nxt = srp_pkg::srp_cmd_t'({data_pin_a_i, cmd_r[7:1]});

	// select high clears the session, so every fall of select restarts at bit zero
	always_ff @(negedge sclk_i or posedge cs_n_i or posedge link_rst_r)
	begin
		if (cs_n_i || link_rst_r)
		begin
			bit_cnt_r <= 5'h00;
			cmd_r     <= '0;
			rx_sh_r   <= 8'h00;
		end
		else
		begin
			if (bit_cnt_r != `SRP_XFER_BITS)
				bit_cnt_r <= bit_cnt_r + 5'h01;
			if (bit_cnt_r < `SRP_CMD_BITS)
				cmd_r <= cmd_nxt;
			else if (bit_cnt_r < `SRP_XFER_BITS)
				rx_sh_r <= {data_pin_a_i, rx_sh_r[7:1]};
		end
	end

	// read data launched on falling edges, lsb first
	always_ff @(negedge sclk_i or posedge cs_n_i or posedge link_rst_r)
	begin
		if (cs_n_i || link_rst_r)
		begin
			drive_r   <= 1'b0;
			out_bit_r <= 1'b0;
			tx_sh_r   <= 7'h00;
		end
		else if (bit_cnt_r == `SRP_CMD_BITS && cmd_r.rd)
		begin
			drive_r   <= 1'b1;
			out_bit_r <= rd_data_r[0];
			tx_sh_r   <= rd_data_r[7:1];
		end
		else if (drive_r && bit_cnt_r < `SRP_XFER_BITS)
		begin
			out_bit_r <= tx_sh_r[0];
			tx_sh_r   <= {1'b0, tx_sh_r[6:1]};
		end
	end

	// requests toggle; only a full sixteenth edge issues a write
	always_ff @(negedge sclk_i or posedge link_rst_r)
	begin
		if (link_rst_r)
		begin
			rd_tgl_r <= 1'b0;
			wr_tgl_r <= 1'b0;
			req_r    <= '0;
		end
		else if (!cs_n_i)
		begin
			if (bit_cnt_r == `SRP_CMD_BITS - 5'h01)
			begin
				req_r.addr <= cmd_nxt.addr;
				if (cmd_nxt.rd)
					rd_tgl_r <= ~rd_tgl_r;
			end
			if (bit_cnt_r == `SRP_XFER_BITS - 5'h01 && !cmd_r.rd)
			begin
				req_r.data <= {data_pin_a_i, rx_sh_r[7:1]};
				wr_tgl_r   <= ~wr_tgl_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// pin routing
	// ----------------------------------------------------------------
	// split gates the enables and pin b data; the launched bit and its timing are shared
	assign data_pin_a_o    = out_bit_r;
	assign data_pin_b_o    = split & out_bit_r;
	assign data_pin_a_oe_o = drive_r & ~split;
	assign data_pin_b_oe_o = drive_r & split;

	// ----------------------------------------------------------------
	// system domain: crossings and register access
	// ----------------------------------------------------------------
	srp_sync #(
		.W (5)
	) u_sync (
		.clk_i (sys_clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   ({rd_tgl_r, wr_tgl_r, tdm_c4_i, tdm_frame_n_i, tdm_in_i}),
		.q_o   (sync_q)
	);

	assign {rd_s, wr_s, c4_s, frame_n_s, tin_s} = sync_q;
	assign rd_evt = rd_s ^ rd_seen_r;
	assign wr_evt = wr_s ^ wr_seen_r;
	assign split   = gcfg_r[`SRP_GCFG_SPLIT_BIT];
	assign slot_en = tctl_r[`SRP_TCTL_SLOT_EN_BIT];

	srp_regmem u_mem (
		.clk_i   (sys_clk_i),
		.ce_i    (ce_i),
		.we_i    (wr_evt),
		.waddr_i (req_r.addr),
		.wdata_i (req_r.data),
		.raddr_i (req_r.addr),
		.rdata_o (mem_q)
	);

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			rd_seen_r <= 1'b0;
			wr_seen_r <= 1'b0;
			rd_pend_r <= 1'b0;
		end
		else if (ce_i)
		begin
			rd_seen_r <= rd_s;
			wr_seen_r <= wr_s;
			rd_pend_r <= rd_evt;
		end
	end

	// limitation: read data must settle within one link period, so sclk stays below ~12 MHz
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			rd_data_r <= 8'h00;
		else if (ce_i && rd_pend_r)
		begin
			case (req_r.addr)
				`SRP_OFS_GCFG: rd_data_r <= gcfg_r;
				`SRP_OFS_TCTL: rd_data_r <= tctl_r;
				`SRP_OFS_CCH:  rd_data_r <= cch_rx_hold_r;
				default:       rd_data_r <= mem_q;
			endcase
		end
	end

	// soft reset bit self-clears and returns the pins to shared mode
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			gcfg_r <= `SRP_GCFG_RST;
			tctl_r <= `SRP_TCTL_RST;
		end
		else if (ce_i && wr_evt)
		begin
			if (req_r.addr == `SRP_OFS_GCFG && req_r.data[`SRP_GCFG_SRST_BIT])
			begin
				gcfg_r <= `SRP_GCFG_RST;
				tctl_r <= `SRP_TCTL_RST;
			end
			else if (req_r.addr == `SRP_OFS_GCFG)
				gcfg_r <= req_r.data;
			else if (req_r.addr == `SRP_OFS_TCTL)
				tctl_r <= req_r.data;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			cch_tx_buf_r <= `SRP_CCH_RST;
		else if (ce_i && wr_evt && req_r.addr == `SRP_OFS_CCH)
			cch_tx_buf_r <= req_r.data;
	end

	// ----------------------------------------------------------------
	// tdm control channel
	// ----------------------------------------------------------------
	assign tdm_fall   = c4_d_r & ~c4_s;
	assign tdm_frame  = tdm_fall & ~frame_n_s;
	assign cell_start = tdm_frame | (tdm_fall & half_r);
	assign idx_nxt    = tdm_frame ? 8'h00 : idx_r + 8'h01;
	assign nxt_in_ch1 = idx_nxt[7:3] == `SRP_CH1_SLOT;
	assign in_ch1     = idx_r[7:3] == `SRP_CH1_SLOT;

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			c4_d_r       <= 1'b0;
			idx_r        <= 8'h00;
			half_r       <= 1'b0;
			cch_tx_cur_r <= `SRP_CCH_RST;
		end
		else if (ce_i)
		begin
			c4_d_r <= c4_s;
			if (tdm_frame)
			begin
				idx_r        <= 8'h00;
				half_r       <= 1'b0;
				cch_tx_cur_r <= cch_tx_buf_r;
			end
			else if (tdm_fall)
			begin
				half_r <= ~half_r;
				if (half_r)
					idx_r <= idx_nxt;
			end
		end
	end

	// msb first on the tdm side; slot tri-stated when disabled
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			tdm_out_o    <= 1'b0;
			tdm_out_oe_o <= 1'b0;
		end
		else if (ce_i && cell_start)
		begin
			tdm_out_o    <= cch_tx_cur_r[~idx_nxt[2:0]];
			tdm_out_oe_o <= slot_en && nxt_in_ch1;
		end
	end

	// receive side always lands in the hold register, enable or not
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			cch_rx_sh_r   <= 8'h00;
			cch_rx_hold_r <= `SRP_CCH_RST;
		end
		else if (ce_i && tdm_fall && !tdm_frame && !half_r && in_ch1)
		begin
			cch_rx_sh_r <= {cch_rx_sh_r[6:0], tin_s};
			if (idx_r == `SRP_CH1_LAST_BIT)
				cch_rx_hold_r <= {cch_rx_sh_r[6:0], tin_s};
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_read_cmd_done;
		bit_cnt_r == `SRP_CMD_BITS && cmd_r.rd;
	endsequence

	sequence s_ch1_cell;
		ce_i && cell_start && nxt_in_ch1 && slot_en;
	endsequence

	chk_idle_hiz: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		cs_n_i |-> !data_pin_a_oe_o && !data_pin_b_oe_o)
		else $error("data pins driven while select high");

	chk_split_route: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		split |-> !data_pin_a_oe_o && data_pin_b_o == (data_pin_b_oe_o & out_bit_r))
		else $error("pin a driven in split mode");

	chk_reset_pins: assert property (@(posedge sys_clk_i)
		rst_i |=> !split && !data_pin_b_oe_o)
		else $error("pin b not disconnected after reset");

	chk_cmd_quiet: assert property (@(negedge sclk_i) disable iff (cs_n_i || link_rst_r)
		bit_cnt_r < `SRP_CMD_BITS |-> !drive_r)
		else $error("device drove during command byte");

	chk_read_launch: assert property (@(negedge sclk_i) disable iff (cs_n_i || link_rst_r)
		s_read_cmd_done |=> drive_r && out_bit_r == $past(rd_data_r[0]) && bit_cnt_r == 5'h09)
		else $error("first read bit not launched on ninth edge");

	chk_early_nowrite: assert property (@(negedge sclk_i) disable iff (cs_n_i || link_rst_r)
		bit_cnt_r != `SRP_XFER_BITS - 5'h01 |=> wr_tgl_r == $past(wr_tgl_r))
		else $error("write issued before sixteenth edge");

	// no shift edge follows the sixteenth, so the toggle is watched from the system clock
	chk_write_issue: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!cs_n_i && $rose(bit_cnt_r == `SRP_XFER_BITS) && !cmd_r.rd |-> $changed(wr_tgl_r))
		else $error("completed write not issued");

	chk_cfg_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && wr_evt && req_r.addr == `SRP_OFS_GCFG && !req_r.data[`SRP_GCFG_SRST_BIT]
		|=> gcfg_r == $past(req_r.data))
		else $error("general config write lost");

	chk_slot_send: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s_ch1_cell |=> tdm_out_oe_o ##0 tdm_out_o == $past(cch_tx_cur_r[~idx_nxt[2:0]]))
		else $error("control channel slot not sent");

	chk_cch_stable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		in_ch1 && !tdm_frame |=> $stable(cch_tx_cur_r))
		else $error("control channel byte changed inside slot");

endmodule : srp_port

/* File: testbench/srp_host.sv */
// host model: drives select, shift clock and serial data lsb first
module srp_host (
	// serial lines to device
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      pin_a_o,
	// device drive
	input  wire logic a_o_i,
	input  wire logic a_oe_i,
	input  wire logic b_o_i,
	input  wire logic b_oe_i
);
	timeunit 1ns;
	timeprecision 100ps;

	logic h_d  = 1'b1;
	logic h_oe = 1'b1;

	// no pull on the pin: a released line shows the inverse of the last level
	assign pin_a_o = a_oe_i ? a_o_i : (h_oe ? h_d : ~h_d);

	initial
	begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
	end

	// ----------------------------------------------------------------
	// one session: command byte then data byte
	// ----------------------------------------------------------------
	task automatic xfer(input logic rd, input logic [5:0] adr, input logic [7:0] wd, input int nb,
		output logic [7:0] rdv, output logic [7:0] oea, output logic [7:0] oeb);
		srp_pkg::srp_cmd_t cmd;
		logic [15:0]       sh;
		cmd = '{rd: rd, spare: 1'b0, addr: adr};
		sh = {wd, cmd};
		rdv = 8'h00;
		oea = 8'h00;
		oeb = 8'h00;
		cs_n_o = 1'b0;
		for (int k = 0; k < nb; k++)
		begin
			h_d = sh[k];
			if (rd && k > 7)
				h_oe = 1'b0;
			#62.5;
			sclk_o = 1'b0;
			#60;
			if (k > 7)
			begin
				rdv[k-8] = b_oe_i ? b_o_i : pin_a_o;
				oea[k-8] = a_oe_i;
				oeb[k-8] = b_oe_i;
			end
			#2.5;
			sclk_o = 1'b1;
		end
		#62.5;
		cs_n_o = 1'b1;
		h_oe = 1'b1;
		// idle gap lets a write land before the next read
		#100;
	endtask : xfer
endmodule : srp_host

/* File: testbench/tb_top.sv */
// testbench of the serial register port and its control channel slot
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [7:0] RXB = 8'h96;

	logic      sys_clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
	logic      tdm_c4_i = 1'b0, tdm_frame_n_i = 1'b1, tdm_in_i = 1'b0;
	wire logic sclk, cs_n, pin_a, a_o, a_oe, b_o, b_oe, tdm_out, tdm_oe;
	int        error_cnt = 0, checked = 0, cyc = 0, frm = 0, f0;
	logic [8:0] pc = '0, fc = '0;
	logic [7:0] cl, cap, capoe, rd, oa, ob;

	srp_port i_srp_port (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.data_pin_a_i(pin_a), .data_pin_a_o(a_o), .data_pin_a_oe_o(a_oe), .data_pin_b_o(b_o),
		.data_pin_b_oe_o(b_oe), .tdm_c4_i(tdm_c4_i), .tdm_frame_n_i(tdm_frame_n_i), .tdm_in_i(tdm_in_i),
		.tdm_out_o(tdm_out), .tdm_out_oe_o(tdm_oe));

	srp_host i_srp_host (.sclk_o(sclk), .cs_n_o(cs_n), .pin_a_o(pin_a), .a_o_i(a_o), .a_oe_i(a_oe),
		.b_o_i(b_o), .b_oe_i(b_oe));

	// ----------------------------------------------------------------
	// clocks, frame and tdm line
	// ----------------------------------------------------------------
	initial
	begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	initial
	begin
		forever #122 tdm_c4_i = ~tdm_c4_i;
	end

	always @(posedge tdm_c4_i)
	begin
		pc <= pc + 9'h001;
		tdm_frame_n_i <= (pc != 9'h1ff);
	end

	// data at cell start, sampled mid cell, channel 1 msb first
	always @(negedge tdm_c4_i)
	begin
		fc = tdm_frame_n_i ? fc + 9'h001 : 9'h000;
		if (!tdm_frame_n_i)
			frm++;
		cl = fc[8:1];
		if (cl >= 8 && cl <= 15)
			if (!fc[0])
				tdm_in_i <= RXB[15-cl];
			else
			begin
				cap[15-cl] <= tdm_out;
				capoe[15-cl] <= tdm_oe;
			end
		else if (!fc[0])
			tdm_in_i <= 1'b0;
	end

	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			error_cnt++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		i_srp_host.xfer(1'b0, a, d, 16, rd, oa, ob);
	endtask : wr

	task automatic rdc(input string nm, input logic [5:0] a, input logic [7:0] exp, input logic sp);
		i_srp_host.xfer(1'b1, a, 8'h00, 16, rd, oa, ob);
		chk(nm, rd, exp);
		chk({nm, "_oea"}, oa, sp ? 8'h00 : 8'hff);
		chk({nm, "_oeb"}, ob, sp ? 8'hff : 8'h00);
		chk({nm, "_idle"}, {6'h00, a_oe, b_oe}, 8'h00);
	endtask : rdc

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		repeat (5) @(negedge sys_clk_i);
		rst_i = 1'b0;
		repeat (6) @(negedge sys_clk_i);
		rdc("gcfg_rst", 6'h0f, 8'h00, 1'b0);
		rdc("tctl_rst", 6'h15, 8'h00, 1'b0);
		$display("test reset done");
		wr(6'h0a, 8'ha5);
		wr(6'h3f, 8'h3c);
		rdc("reg0a", 6'h0a, 8'ha5, 1'b0);
		rdc("reg3f", 6'h3f, 8'h3c, 1'b0);
		$display("test access done");
		i_srp_host.xfer(1'b0, 6'h0a, 8'h5a, 12, rd, oa, ob);
		rdc("abort", 6'h0a, 8'ha5, 1'b0);
		$display("test abort done");
		wr(6'h0f, 8'h01);
		rdc("split", 6'h0a, 8'ha5, 1'b1);
		rdc("gcfg_sp", 6'h0f, 8'h01, 1'b1);
		wr(6'h0f, 8'h80);
		rdc("srst", 6'h0f, 8'h00, 1'b0);
		$display("test split done");
		wr(6'h14, 8'hc3);
		wr(6'h15, 8'h01);
		f0 = frm;
		wait (frm == f0 + 2);
		chk("cch_tx", cap, 8'hc3);
		chk("cch_oe", capoe, 8'hff);
		rdc("cch_rx", 6'h14, RXB, 1'b0);
		wr(6'h15, 8'h00);
		f0 = frm;
		wait (frm == f0 + 2);
		chk("cch_off", capoe, 8'h00);
		$display("test channel done");
		print_verdict();
	end
endmodule : tb_top
